//--- hdl/timer16_pkg.sv
// constants, register map and mode encodings of the 16-bit timer/counter
package timer16_pkg;

  typedef enum logic [3:0] {
    WAVE_NORMAL     = 4'h0,
    WAVE_PC8        = 4'h1,
    WAVE_PC9        = 4'h2,
    WAVE_PC10       = 4'h3,
    WAVE_CTC_CMP    = 4'h4,
    WAVE_FAST8      = 4'h5,
    WAVE_FAST9      = 4'h6,
    WAVE_FAST10     = 4'h7,
    WAVE_PFC_CAP    = 4'h8,
    WAVE_PFC_CMP    = 4'h9,
    WAVE_PC_CAP     = 4'ha,
    WAVE_PC_CMP     = 4'hb,
    WAVE_CTC_CAP    = 4'hc,
    WAVE_RESERVED   = 4'hd,
    WAVE_FAST_CAP   = 4'he,
    WAVE_FAST_CMP   = 4'hf
  } wave_mode_t;

  typedef enum logic [2:0] {
    CLK_STOP     = 3'h0,
    CLK_DIV1     = 3'h1,
    CLK_DIV8     = 3'h2,
    CLK_DIV64    = 3'h3,
    CLK_DIV256   = 3'h4,
    CLK_DIV1024  = 3'h5,
    CLK_EXT_FALL = 3'h6,
    CLK_EXT_RISE = 3'h7
  } clock_sel_t;

  // register locations on the 8-bit bus
  localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LO = 4'h2;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h3;
  localparam logic [3:0] ADDR_CAPT_LO  = 4'h4;
  localparam logic [3:0] ADDR_CAPT_HI  = 4'h5;
  localparam logic [3:0] ADDR_CMP_LO   = 4'h6;
  localparam logic [3:0] ADDR_CMP_HI   = 4'h7;
  localparam logic [3:0] ADDR_FLAGS    = 4'h8;
  localparam logic [3:0] ADDR_MASK     = 4'h9;

  // field positions
  localparam int CTRL_B_WAVE_LSB  = 3;
  localparam int CTRL_B_EDGE_BIT  = 6;
  localparam int CTRL_B_SRC_BIT   = 7;
  localparam int FLAG_OVF_BIT     = 0;
  localparam int FLAG_CAPT_BIT    = 5;

  // values after reset
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CAPT_RESET  = 16'h0000;
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam logic [7:0]  TEMP_RESET  = 8'h00;
  localparam logic [7:0]  DATA_RESET  = 8'h00;

  // fixed ceilings and prescaler
  localparam logic [15:0] TOP_MAX   = 16'hffff;
  localparam logic [15:0] TOP_8BIT  = 16'h00ff;
  localparam logic [15:0] TOP_9BIT  = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam int          PRESCALE_W = 10;

endpackage : timer16_pkg

//--- hdl/count_core.sv
// 16-bit up/down counter core with floor and ceiling detection
`timescale 1ns/1ps
module count_core
  import timer16_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic        dual_slope,
  input  wire logic [15:0] top_value,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  output logic      [15:0] count,
  output logic             counting_down,
  output logic             at_floor,
  output logic             at_ceiling
);

  logic        next_down;
  logic [15:0] next_count;

  assign at_floor   = (count == 16'h0000);
  assign at_ceiling = (count == top_value);

  // dual slope turns at the ceiling and at the floor
  assign next_down  = dual_slope ? (counting_down ? !at_floor : (count >= top_value)) : 1'b0;
  // single slope clears after the ceiling
  assign next_count = !dual_slope ? (at_ceiling ? 16'h0000 : count + 16'h0001)
                                  : (next_down ? count - 16'h0001 : count + 16'h0001);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count         <= COUNT_RESET;
      counting_down <= 1'b0;
    end
    else if (load)
    begin
      count <= load_value;
    end
    else if (tick)
    begin
      count         <= next_count;
      counting_down <= next_down;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_load_overrides: assert property (load |=> count == $past(load_value))
    else $error("cpu load did not win over counting");
  a_single_wrap: assert property (tick && !load && !dual_slope && at_ceiling |=> at_floor)
    else $error("single slope did not clear after ceiling");
  a_count_step: assert property (tick && !load && !dual_slope && !at_ceiling
                                 |=> count == $past(count) + 16'h0001)
    else $error("counter did not step by one");

endmodule : count_core

//--- hdl/timer16_counter_capture.sv
// 16-bit timer/counter with shared high-byte holding register and input capture
`timescale 1ns/1ps
// Overview of operation
// - counter counts up or down by one per tick, or clears to zero
// - floor shows at zero, ceiling shows at the sequence top
// - reading count low byte copies count high byte into holding register
// - writing count low byte loads counter from holding byte plus written byte
// - high byte locations of count and capture reach the holding register
// - holding register keeps its value so one high byte serves many writes
// - three-bit clock select field in control register b picks tick source
// - clock select zero stops the counter, which keeps its value
// - cpu reads and writes the counter with or without a running tick
// - cpu write to counter beats a coinciding count or clear
// - four-bit waveform mode split over control registers a and b
// - overflow flag sets where the mode says and can request interrupt
// - capture from pin edge, or from comparator output on this timer
// - capture copies full count and sets capture flag in one cycle
// - enabled capture flag requests interrupt and clears when serviced
// - writing one clears the capture flag, zero leaves it
// - capture low byte read first latches capture high into holding register
// - capture register writable only in modes that use it as ceiling
// - one holding register is shared by all 16-bit registers here
// - compare register reads return both bytes without the holding register
module timer16_counter_capture
  import timer16_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       capture_input_pin,
  input  wire logic       comparator_result,
  input  wire logic       ext_clock_pin,
  input  wire logic       capture_irq_ack,
  input  wire logic       overflow_irq_ack,
  output logic            capture_irq,
  output logic            overflow_irq,
  output logic            count_floor,
  output logic            count_ceiling
);

  function automatic logic icr_is_top(input wave_mode_t m);
    icr_is_top = (m == WAVE_PFC_CAP) || (m == WAVE_PC_CAP) ||
                 (m == WAVE_CTC_CAP) || (m == WAVE_FAST_CAP);
  endfunction : icr_is_top

  function automatic logic is_dual(input wave_mode_t m);
    is_dual = (m == WAVE_PC8) || (m == WAVE_PC9) || (m == WAVE_PC10) ||
              (m == WAVE_PFC_CAP) || (m == WAVE_PFC_CMP) ||
              (m == WAVE_PC_CAP) || (m == WAVE_PC_CMP);
  endfunction : is_dual

  function automatic logic [15:0] top_for(input wave_mode_t  m,
                                          input logic [15:0] capt,
                                          input logic [15:0] cmp);
    unique case (m)
      WAVE_PC8, WAVE_FAST8:                     top_for = TOP_8BIT;
      WAVE_PC9, WAVE_FAST9:                     top_for = TOP_9BIT;
      WAVE_PC10, WAVE_FAST10:                   top_for = TOP_10BIT;
      WAVE_CTC_CMP, WAVE_PFC_CMP, WAVE_PC_CMP,
      WAVE_FAST_CMP:                            top_for = cmp;
      WAVE_PFC_CAP, WAVE_PC_CAP, WAVE_CTC_CAP,
      WAVE_FAST_CAP:                            top_for = capt;
      WAVE_NORMAL, WAVE_RESERVED:               top_for = TOP_MAX;
    endcase
  endfunction : top_for

  // control and data state
  logic [1:0]            wave_lo;
  logic [1:0]            wave_hi;
  clock_sel_t            clock_sel;
  logic                  edge_rising;
  logic                  src_comparator;
  logic [7:0]            temp;
  logic [15:0]           capture;
  logic [15:0]           compare;
  logic                  capture_flag;
  logic                  overflow_flag;
  logic                  capture_irq_enable;
  logic                  overflow_irq_enable;
  logic [PRESCALE_W-1:0] prescale;
  logic                  ext_prev;
  logic                  src_prev;

  wire logic [15:0] count;
  wire logic        counting_down;
  wire logic        at_floor;
  wire logic        at_ceiling;

  // address decode
  wire logic wr_ctrl_a   = reg_wr && (reg_addr == ADDR_CTRL_A);
  wire logic wr_ctrl_b   = reg_wr && (reg_addr == ADDR_CTRL_B);
  wire logic wr_count_lo = reg_wr && (reg_addr == ADDR_COUNT_LO);
  wire logic wr_capt_lo  = reg_wr && (reg_addr == ADDR_CAPT_LO);
  wire logic wr_cmp_lo   = reg_wr && (reg_addr == ADDR_CMP_LO);
  wire logic wr_flags    = reg_wr && (reg_addr == ADDR_FLAGS);
  wire logic wr_mask     = reg_wr && (reg_addr == ADDR_MASK);
  wire logic wr_high     = reg_wr && ((reg_addr == ADDR_COUNT_HI) ||
                                      (reg_addr == ADDR_CAPT_HI) ||
                                      (reg_addr == ADDR_CMP_HI));
  wire logic rd_count_lo = reg_rd && (reg_addr == ADDR_COUNT_LO);
  wire logic rd_capt_lo  = reg_rd && (reg_addr == ADDR_CAPT_LO);

  wire wave_mode_t mode       = wave_mode_t'({wave_hi, wave_lo});
  wire logic       dual_slope = is_dual(mode);
  wire logic       capt_top   = icr_is_top(mode);
  wire logic [15:0] top_value = top_for(mode, capture, compare);

  // tick source; external pin is taken as synchronous
  wire logic ext_rise = ext_clock_pin && !ext_prev;
  wire logic ext_fall = !ext_clock_pin && ext_prev;
  wire logic tick = (clock_sel == CLK_DIV1) ||
                    ((clock_sel == CLK_DIV8)    && (&prescale[2:0])) ||
                    ((clock_sel == CLK_DIV64)   && (&prescale[5:0])) ||
                    ((clock_sel == CLK_DIV256)  && (&prescale[7:0])) ||
                    ((clock_sel == CLK_DIV1024) && (&prescale[9:0])) ||
                    ((clock_sel == CLK_EXT_FALL) && ext_fall) ||
                    ((clock_sel == CLK_EXT_RISE) && ext_rise);

  // capture trigger; switching source may itself look like an edge
  wire logic capt_src  = src_comparator ? comparator_result : capture_input_pin;
  wire logic src_rise  = capt_src && !src_prev;
  wire logic src_fall  = !capt_src && src_prev;
  // input path is idle while the capture register holds the ceiling
  wire logic capture_fire = !capt_top && (edge_rising ? src_rise : src_fall);

  wire logic ovf_event = tick && !wr_count_lo &&
                         (dual_slope ? (counting_down && at_floor) : at_ceiling);

  // holding register: high writes first, then low-byte reads
  wire logic [7:0] next_temp = wr_high     ? reg_wdata :
                               rd_count_lo ? count[15:8] :
                               rd_capt_lo  ? capture[15:8] : temp;

  // set wins over every clear
  wire logic next_capture_flag = capture_fire ||
                                 (capture_flag &&
                                  !(wr_flags && reg_wdata[FLAG_CAPT_BIT]) &&
                                  !capture_irq_ack);
  wire logic next_overflow_flag = ovf_event ||
                                  (overflow_flag &&
                                   !(wr_flags && reg_wdata[FLAG_OVF_BIT]) &&
                                   !overflow_irq_ack);

  wire logic [7:0] ctrl_b_read = {src_comparator, edge_rising, 1'b0, wave_hi, clock_sel};
  wire logic [7:0] flags_read  = {2'b00, capture_flag, 4'h0, overflow_flag};
  wire logic [7:0] mask_read   = {2'b00, capture_irq_enable, 4'h0, overflow_irq_enable};
  wire logic [7:0] next_rdata  =
      (reg_addr == ADDR_CTRL_A)   ? {6'h00, wave_lo} :
      (reg_addr == ADDR_CTRL_B)   ? ctrl_b_read :
      (reg_addr == ADDR_COUNT_LO) ? count[7:0] :
      (reg_addr == ADDR_COUNT_HI) ? temp :
      (reg_addr == ADDR_CAPT_LO)  ? capture[7:0] :
      (reg_addr == ADDR_CAPT_HI)  ? temp :
      (reg_addr == ADDR_CMP_LO)   ? compare[7:0] :
      (reg_addr == ADDR_CMP_HI)   ? compare[15:8] :
      (reg_addr == ADDR_FLAGS)    ? flags_read :
      (reg_addr == ADDR_MASK)     ? mask_read : DATA_RESET;

  count_core u_count (
    .clk           (clk),
    .rst_b         (rst_b),
    .tick          (tick),
    .dual_slope    (dual_slope),
    .top_value     (top_value),
    .load          (wr_count_lo),
    .load_value    ({temp, reg_wdata}),
    .count         (count),
    .counting_down (counting_down),
    .at_floor      (at_floor),
    .at_ceiling    (at_ceiling)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wave_lo        <= 2'b00;
      wave_hi        <= 2'b00;
      clock_sel      <= CLK_STOP;
      edge_rising    <= 1'b0;
      src_comparator <= 1'b0;
    end
    else
    begin
      if (wr_ctrl_a)
        wave_lo <= reg_wdata[1:0];
      if (wr_ctrl_b)
      begin
        clock_sel      <= clock_sel_t'(reg_wdata[2:0]);
        wave_hi        <= reg_wdata[CTRL_B_WAVE_LSB+1:CTRL_B_WAVE_LSB];
        edge_rising    <= reg_wdata[CTRL_B_EDGE_BIT];
        src_comparator <= reg_wdata[CTRL_B_SRC_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      temp    <= TEMP_RESET;
      capture <= CAPT_RESET;
      compare <= CMP_RESET;
    end
    else
    begin
      temp <= next_temp;
      if (capture_fire)
        capture <= count;
      else if (wr_capt_lo && capt_top)
        capture <= {temp, reg_wdata};
      if (wr_cmp_lo)
        compare <= {temp, reg_wdata};
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      capture_flag        <= 1'b0;
      overflow_flag       <= 1'b0;
      capture_irq_enable  <= 1'b0;
      overflow_irq_enable <= 1'b0;
      capture_irq         <= 1'b0;
      overflow_irq        <= 1'b0;
    end
    else
    begin
      capture_flag  <= next_capture_flag;
      overflow_flag <= next_overflow_flag;
      if (wr_mask)
      begin
        capture_irq_enable  <= reg_wdata[FLAG_CAPT_BIT];
        overflow_irq_enable <= reg_wdata[FLAG_OVF_BIT];
      end
      capture_irq  <= next_capture_flag && capture_irq_enable;
      overflow_irq <= next_overflow_flag && overflow_irq_enable;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescale      <= '0;
      ext_prev      <= 1'b0;
      src_prev      <= 1'b0;
      reg_rdata     <= DATA_RESET;
      count_floor   <= 1'b1;
      count_ceiling <= 1'b0;
    end
    else
    begin
      prescale      <= prescale + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      ext_prev      <= ext_clock_pin;
      src_prev      <= capt_src;
      if (reg_rd)
        reg_rdata <= next_rdata;
      count_floor   <= at_floor;
      count_ceiling <= at_ceiling;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_low_read_latch: assert property (rd_count_lo && !reg_wr
                                     |=> temp == $past(count[15:8]))
    else $error("count low read did not latch high byte");
  a_low_write_load: assert property (wr_count_lo
                                     |=> count == {$past(temp), $past(reg_wdata)})
    else $error("count low write did not load both bytes");
  a_high_read_temp: assert property (reg_rd && reg_addr == ADDR_COUNT_HI
                                     |=> reg_rdata == $past(temp))
    else $error("count high read bypassed holding register");
  a_temp_kept: assert property (!reg_wr && !rd_count_lo && !rd_capt_lo
                                |=> $stable(temp))
    else $error("holding register changed without access");
  a_stop_holds: assert property (clock_sel == CLK_STOP && !wr_count_lo
                                 |=> $stable(count))
    else $error("stopped counter moved");
  a_div1_tick: assert property (clock_sel == CLK_DIV1 && !wr_count_lo && !dual_slope &&
                                !at_ceiling |=> count == $past(count) + 16'h0001)
    else $error("undivided clock did not advance counter");
  a_capture_copy: assert property (capture_fire
                                   |=> capture == $past(count) && capture_flag)
    else $error("capture missed count or flag");
  a_flag_w1c: assert property (capture_flag && wr_flags && reg_wdata[FLAG_CAPT_BIT] &&
                               !capture_fire |=> !capture_flag)
    else $error("writing one did not clear capture flag");
  a_flag_w0_keep: assert property (capture_flag && wr_flags && !reg_wdata[FLAG_CAPT_BIT] &&
                                   !capture_irq_ack |=> capture_flag)
    else $error("writing zero cleared capture flag");
  a_capture_irq: assert property (capture_fire && capture_irq_enable |=> capture_irq)
    else $error("enabled capture did not request interrupt");
  a_capt_write_guard: assert property (wr_capt_lo && !capt_top && !capture_fire
                                       |=> $stable(capture))
    else $error("capture register written outside ceiling mode");
  a_cmp_read_direct: assert property (reg_rd && reg_addr == ADDR_CMP_HI && !reg_wr
                                      |=> reg_rdata == $past(compare[15:8]) &&
                                          $stable(temp))
    else $error("compare read used holding register");
  a_overflow_set: assert property (ovf_event |=> overflow_flag)
    else $error("overflow event did not set flag");

  c_capture_seen: cover property (capture_fire ##1 capture_irq);
  c_overflow_seen: cover property (ovf_event ##1 overflow_irq);
  c_word_write: cover property (wr_high ##[1:4] wr_count_lo);
  c_dual_turn: cover property (dual_slope && tick && at_ceiling ##1 counting_down);

endmodule : timer16_counter_capture

//--- bench/cpu_model.sv
// cpu core model: byte accesses and interrupt service on the timer bus
`timescale 1ns/1ps
module cpu_model (
  input  wire logic       clk,
  output logic      [3:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  output logic            capture_irq_ack,
  output logic            overflow_irq_ack
);
  initial
  begin
    reg_addr         = 4'h0;
    reg_wr           = 1'b0;
    reg_rd           = 1'b0;
    reg_wdata        = 8'h00;
    capture_irq_ack  = 1'b0;
    overflow_irq_ack = 1'b0;
  end

  // strobe held over one rising edge, dropped at the following falling edge
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(negedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d; // stale data never left on the bus
  endtask : wr8

  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(negedge clk);
    reg_rd <= 1'b0;
    d = reg_rdata;
  endtask : rd8

  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(lo + 4'h1, v[15:8]);
  endtask : rd16

  task automatic service(input logic capt);
    @(negedge clk);
    capture_irq_ack  <= capt;
    overflow_irq_ack <= !capt;
    @(negedge clk);
    capture_irq_ack  <= 1'b0;
    overflow_irq_ack <= 1'b0;
  endtask : service
endmodule : cpu_model

//--- bench/testbench.sv
// self-checking bench for the 16-bit timer/counter with capture
`timescale 1ns/1ps
module testbench
  import timer16_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cap_pin = 1'b0;
  logic       cmp_out = 1'b0;
  logic       ext_pin = 1'b0;
  logic [3:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       cap_ack;
  logic       ovf_ack;
  logic       capture_irq;
  logic       overflow_irq;
  logic       count_floor;
  logic       count_ceiling;
  int         mismatches = 0;
  int         n_tests = 0;

  timer16_counter_capture u_timer16_counter_capture (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .capture_input_pin(cap_pin), .comparator_result(cmp_out),
    .ext_clock_pin(ext_pin), .capture_irq_ack(cap_ack), .overflow_irq_ack(ovf_ack),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq), .count_floor(count_floor),
    .count_ceiling(count_ceiling));

  cpu_model u_cpu_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .capture_irq_ack(cap_ack),
    .overflow_irq_ack(ovf_ack));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic t_reset;
    logic [15:0] v;
    logic [7:0]  b;
    u_cpu_model.rd16(ADDR_COUNT_LO, v);
    check("count", v, COUNT_RESET);
    u_cpu_model.rd16(ADDR_CAPT_LO, v);
    check("capture", v, CAPT_RESET);
    u_cpu_model.rd8(ADDR_FLAGS, b);
    check("flags", {8'h00, b}, 16'h0000);
    check("floor", {15'h0, count_floor}, 16'h0001);
  endtask : t_reset

  task automatic t_access;
    logic [15:0] v;
    logic [7:0]  b;
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h01ff);
    repeat (10) @(negedge clk);
    u_cpu_model.rd16(ADDR_COUNT_LO, v);
    check("count", v, 16'h01ff);
    u_cpu_model.wr8(ADDR_COUNT_HI, 8'hab);
    u_cpu_model.wr8(ADDR_COUNT_LO, 8'h12);
    u_cpu_model.wr8(ADDR_CMP_LO, 8'h34);
    u_cpu_model.wr8(ADDR_COUNT_HI, 8'h77);
    u_cpu_model.rd8(ADDR_CMP_HI, b);
    check("compare high", {8'h00, b}, 16'h00ab);
    u_cpu_model.rd8(ADDR_COUNT_HI, b);
    check("holding", {8'h00, b}, 16'h0077);
    u_cpu_model.rd16(ADDR_COUNT_LO, v);
    check("count", v, 16'hab12);
  endtask : t_access

  task automatic t_count;
    logic [7:0] a;
    logic [7:0] b;
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h0000);
    u_cpu_model.wr8(ADDR_MASK, 8'h01);
    u_cpu_model.wr8(ADDR_CTRL_B, {5'h00, CLK_DIV1});
    u_cpu_model.rd8(ADDR_COUNT_LO, a);
    u_cpu_model.rd8(ADDR_COUNT_LO, b);
    check("step", {8'h00, 8'(b - a)}, 16'h0002);
    // write lands on a ticking counter, one tick passes before the read
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'hfff0);
    u_cpu_model.rd8(ADDR_COUNT_LO, b);
    check("write wins", {8'h00, b}, 16'h00f1);
    repeat (20) @(negedge clk);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
    check("overflow irq", {15'h0, overflow_irq}, 16'h0001);
    u_cpu_model.service(1'b0);
    check("overflow irq", {15'h0, overflow_irq}, 16'h0000);
    u_cpu_model.rd8(ADDR_COUNT_LO, a);
    repeat (10) @(negedge clk);
    u_cpu_model.rd8(ADDR_COUNT_LO, b);
    check("stopped", {8'h00, b}, {8'h00, a});
  endtask : t_count

  task automatic t_ext;
    logic [15:0] v;
    for (int cs = 6; cs <= 7; cs++)
    begin
      u_cpu_model.wr16(ADDR_COUNT_LO, 16'h0000);
      u_cpu_model.wr8(ADDR_CTRL_B, 8'(cs));
      repeat (3)
      begin
        @(negedge clk) ext_pin = 1'b1;
        repeat (2) @(negedge clk);
        ext_pin = 1'b0;
        repeat (2) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      u_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
      u_cpu_model.rd16(ADDR_COUNT_LO, v);
      check("ext count", v, 16'h0003);
    end
  endtask : t_ext

  task automatic t_capture;
    logic [15:0] v;
    logic [7:0]  b;
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h1234);
    u_cpu_model.wr8(ADDR_MASK, 8'h20);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h40);
    @(negedge clk) cap_pin = 1'b1;
    repeat (2) @(negedge clk);
    check("capture irq", {15'h0, capture_irq}, 16'h0001);
    u_cpu_model.rd16(ADDR_CAPT_LO, v);
    check("capture", v, 16'h1234);
    u_cpu_model.wr8(ADDR_FLAGS, 8'h00);
    u_cpu_model.rd8(ADDR_FLAGS, b);
    check("flags", {8'h00, b}, 16'h0020);
    u_cpu_model.wr8(ADDR_FLAGS, 8'h20);
    u_cpu_model.rd8(ADDR_FLAGS, b);
    check("flags", {8'h00, b}, 16'h0000);
    // a source switch may fake an edge, so the flag is cleared after it
    u_cpu_model.wr8(ADDR_CTRL_B, 8'hc0);
    u_cpu_model.wr8(ADDR_FLAGS, 8'h20);
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h0777);
    @(negedge clk) cmp_out = 1'b1;
    repeat (2) @(negedge clk);
    check("capture irq", {15'h0, capture_irq}, 16'h0001);
    u_cpu_model.service(1'b1);
    check("capture irq", {15'h0, capture_irq}, 16'h0000);
    u_cpu_model.rd16(ADDR_CAPT_LO, v);
    check("capture", v, 16'h0777);
  endtask : t_capture

  task automatic t_ceiling;
    logic [15:0] v;
    u_cpu_model.wr16(ADDR_CAPT_LO, 16'hbeef);
    u_cpu_model.rd16(ADDR_CAPT_LO, v);
    check("capture", v, 16'h0777);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h18);
    u_cpu_model.wr16(ADDR_CAPT_LO, 16'h00c8);
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h00c8);
    repeat (3) @(negedge clk);
    check("ceiling", {15'h0, count_ceiling}, 16'h0001);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
    u_cpu_model.wr8(ADDR_CTRL_A, 8'h01);
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h00ff);
    repeat (3) @(negedge clk);
    check("ceiling", {15'h0, count_ceiling}, 16'h0001);
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h0000);
    repeat (3) @(negedge clk);
    check("floor", {15'h0, count_floor}, 16'h0001);
  endtask : t_ceiling

  task automatic t_modes;
    logic [7:0] a;
    logic [7:0] b;
    int         span;
    // dual slope 8-bit: climbs to the top, turns, falls to the floor
    u_cpu_model.wr8(ADDR_CTRL_A, 8'h01);
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h00fc);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h01);
    repeat (4) @(negedge clk);
    u_cpu_model.rd8(ADDR_COUNT_LO, a);
    u_cpu_model.rd8(ADDR_COUNT_LO, b);
    check("down step", {8'h00, 8'(a - b)}, 16'h0002);
    repeat (300) @(negedge clk);
    u_cpu_model.rd8(ADDR_FLAGS, b);
    check("floor overflow", {8'h00, b}, 16'h0001);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
    u_cpu_model.wr8(ADDR_FLAGS, 8'h01);
    // two prescaler periods hold exactly two ticks at any phase
    u_cpu_model.wr8(ADDR_CTRL_A, 8'h00);
    for (int cs = 2; cs <= 5; cs++)
    begin
      span = (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
      u_cpu_model.wr8(ADDR_CTRL_B, 8'(cs));
      u_cpu_model.rd8(ADDR_COUNT_LO, a);
      repeat (2 * span - 2) @(negedge clk);
      u_cpu_model.rd8(ADDR_COUNT_LO, b);
      check("prescaled step", {8'h00, 8'(b - a)}, 16'h0002);
    end
    // compare value as ceiling: back to zero after six ticks
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
    u_cpu_model.wr16(ADDR_CMP_LO, 16'h0005);
    u_cpu_model.wr16(ADDR_COUNT_LO, 16'h0000);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h09);
    u_cpu_model.rd8(ADDR_COUNT_LO, a);
    repeat (3) @(negedge clk);
    u_cpu_model.rd8(ADDR_COUNT_LO, b);
    check("compare top", {a, b}, 16'h0100);
    u_cpu_model.wr8(ADDR_CTRL_B, 8'h00);
  endtask : t_modes

  initial
  begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset();
    t_access();
    t_count();
    t_ext();
    t_capture();
    t_ceiling();
    t_modes();
    give_verdict();
  end

  // the scenarios need well under ten thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : testbench
